/* pkg/core_regs_map.vh */
// Register offsets, field positions, reset values and operation codes for the core register block.
`ifndef CORE_REGS_MAP_VH
`define CORE_REGS_MAP_VH

// Byte offsets of the bus registers.
`define OFF_BANK 8'h00
`define OFF_WREG 8'h04
`define OFF_PCL 8'h08
`define OFF_TABLE_POINTER_LOW 8'h0c
`define OFF_TABLE_POINTER_HIGH 8'h10
`define OFF_TABLE_RESULT_HIGH 8'h14
`define OFF_STATUS 8'h18
`define OFF_EE_ADDR 8'h1c
`define OFF_EE_DATA 8'h20

// Status field positions.
`define ST_CARRY 0
`define ST_HALF 1
`define ST_ZERO 2
`define ST_WRAP 3
`define ST_PDOWN 4
`define ST_TOUT 5

// Reset values and store depth.
`define RST_BYTE 8'h00
`define RST_FLAGS 4'h0
`define EE_DEPTH 64

// Operation codes from the instruction sequencer.
`define OP_MOVW 4'h0
`define OP_ADD 4'h1
`define OP_ADC 4'h2
`define OP_SUB 4'h3
`define OP_SBC 4'h4
`define OP_AND 4'h5
`define OP_OR 4'h6
`define OP_XOR 4'h7
`define OP_RLC 4'h8
`define OP_RRC 4'h9
`define OP_INC 4'ha
`define OP_DEC 4'hb
`define OP_CPL 4'hc

`endif

/* verilog/core_status_and_bank_regs.v */
// Core status, bank, working, program counter low and table registers with an AHB-Lite slave.
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "core_regs_map.vh"

module core_status_and_bank_regs (
	// Clock and reset.
	input wire hclk,
	input wire hresetn,
	// AHB-Lite slave.
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	// ALU request from the sequencer.
	input wire alu_valid,
	input wire [3:0] alu_op,
	input wire [7:0] alu_operand,
	output reg [7:0] working_register,
	// Program counter low byte jump.
	output reg [7:0] program_counter_low_byte,
	output reg pc_jump,
	output reg dummy_cycle,
	// Table read.
	input wire table_read_req,
	output wire [15:0] table_addr,
	output reg table_fetch,
	input wire table_word_valid,
	input wire [15:0] table_word,
	output reg [7:0] table_low_data,
	output reg table_low_valid,
	// System events.
	input wire sleep_exec,
	input wire watchdog_clear_instruction,
	input wire watchdog_expired,
	input wire soft_reset,
	input wire soft_reset_from_wdt,
	// Data memory bank steering.
	input wire access_indirect_mp1,
	output wire access_bank
);

	// Bus and architectural state.
	reg bank_select_bit;
	reg [7:0] table_pointer_low;
	reg [7:0] table_pointer_high;
	reg [7:0] table_result_high;
	reg watchdog_expired_flag;
	reg power_down_flag;
	reg signed_wrap_flag;
	reg zero_flag;
	reg half_carry_flag;
	reg carry_flag;
	reg [5:0] ee_addr_q;
	reg [7:0] ee_store [0:`EE_DEPTH-1];
	reg wr_pend_q;
	reg [7:0] addr_q;
	reg table_wait_q;

	// ALU result and flags.
	reg [7:0] res_d;
	reg c_d;
	reg h_d;
	reg v_d;
	reg c_def;
	reg hv_def;
	reg z_def;
	reg res_def;

	wire bus_start;
	wire bus_wr;
	wire [7:0] wb;
	wire [7:0] status_rd;
	reg [7:0] rd_byte;

	// Adder shared by add, add with carry, subtract and subtract with borrow; returns {carry8, half, carry7, sum}.
	function [10:0] add8;
		input [7:0] a;
		input [7:0] b;
		input cin;
		reg [4:0] lo;
		reg [3:0] mid;
		reg [1:0] hi;
		begin
			lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
			mid = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, lo[4]};
			hi = {1'b0, a[7]} + {1'b0, b[7]} + {1'b0, mid[3]};
			add8 = {hi[1], lo[4], mid[3], hi[0], mid[2:0], lo[3:0]};
		end
	endfunction

	// Zero-wait slave: every transfer completes in one data phase, always OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign bus_start = hsel & hready & htrans[1];
	assign bus_wr = wr_pend_q;
	assign wb = hwdata[7:0];

	// Address phase capture; a write is committed in the following data phase.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= `RST_BYTE;
			wr_pend_q <= 1'b0;
		end else begin
			wr_pend_q <= bus_start & hwrite;
			if (bus_start) begin
				addr_q <= haddr[7:0];
			end
		end
	end

	// Status image: bits 7..6 read zero, flags in their fixed places.
	assign status_rd = {2'b00, watchdog_expired_flag, power_down_flag, signed_wrap_flag, zero_flag,
		half_carry_flag, carry_flag};

	// Read mux over the registered address; unmapped offsets read zero.
	always @* begin
		case (addr_q)
			`OFF_BANK: rd_byte = {7'h00, bank_select_bit};
			`OFF_WREG: rd_byte = working_register;
			`OFF_PCL: rd_byte = program_counter_low_byte;
			`OFF_TABLE_POINTER_LOW: rd_byte = table_pointer_low;
			`OFF_TABLE_POINTER_HIGH: rd_byte = table_pointer_high;
			`OFF_TABLE_RESULT_HIGH: rd_byte = table_result_high;
			`OFF_STATUS: rd_byte = status_rd;
			`OFF_EE_ADDR: rd_byte = {2'b00, ee_addr_q};
			`OFF_EE_DATA: rd_byte = ee_store[ee_addr_q];
			default: rd_byte = `RST_BYTE;
		endcase
	end
	assign hrdata = {24'h000000, rd_byte};

	// Direct addressing never leaves bank 0; only the second pointer follows the bank bit.
	assign access_bank = access_indirect_mp1 & bank_select_bit;
	assign table_addr = {table_pointer_high, table_pointer_low};

	// Operation decode; a flag whose *_def stays low keeps its old value.
	always @* begin
		res_d = working_register;
		c_d = carry_flag;
		h_d = half_carry_flag;
		v_d = signed_wrap_flag;
		c_def = 1'b0;
		hv_def = 1'b0;
		z_def = 1'b0;
		res_def = 1'b1;
		case (alu_op)
			`OP_MOVW: res_d = alu_operand;
			`OP_ADD: begin
				{c_d, h_d, v_d, res_d} = add8(working_register, alu_operand, 1'b0);
				{c_def, hv_def, z_def} = 3'b111;
			end
			`OP_ADC: begin
				{c_d, h_d, v_d, res_d} = add8(working_register, alu_operand, carry_flag);
				{c_def, hv_def, z_def} = 3'b111;
			end
			`OP_SUB: begin
				// Subtract as add of the complement: carry out high means no borrow.
				{c_d, h_d, v_d, res_d} = add8(working_register, ~alu_operand, 1'b1);
				{c_def, hv_def, z_def} = 3'b111;
			end
			`OP_SBC: begin
				{c_d, h_d, v_d, res_d} = add8(working_register, ~alu_operand, carry_flag);
				{c_def, hv_def, z_def} = 3'b111;
			end
			`OP_AND: begin
				res_d = working_register & alu_operand;
				z_def = 1'b1;
			end
			`OP_OR: begin
				res_d = working_register | alu_operand;
				z_def = 1'b1;
			end
			`OP_XOR: begin
				res_d = working_register ^ alu_operand;
				z_def = 1'b1;
			end
			`OP_RLC: begin
				res_d = {alu_operand[6:0], carry_flag};
				{c_d, c_def} = {alu_operand[7], 1'b1};
			end
			`OP_RRC: begin
				res_d = {carry_flag, alu_operand[7:1]};
				{c_d, c_def} = {alu_operand[0], 1'b1};
			end
			`OP_INC: begin
				res_d = alu_operand + 8'h01;
				z_def = 1'b1;
			end
			`OP_DEC: begin
				res_d = alu_operand - 8'h01;
				z_def = 1'b1;
			end
			`OP_CPL: begin
				res_d = ~alu_operand;
				z_def = 1'b1;
			end
			default: res_def = 1'b0;
		endcase
		// The adder packs carry7 into v_d; overflow is carry7 against carry8.
		v_d = hv_def ? (v_d ^ c_d) : signed_wrap_flag;
	end

	// Working register: ALU results of defined operations land here; a bus write in the same cycle wins.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			working_register <= `RST_BYTE;
		end else if (bus_wr && addr_q == `OFF_WREG) begin
			working_register <= wb;
		end else if (alu_valid && res_def) begin
			working_register <= res_d;
		end
	end

	// Arithmetic flags; undefined flags hold, bus writes override ALU updates.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{signed_wrap_flag, zero_flag, half_carry_flag, carry_flag} <= `RST_FLAGS;
		end else if (bus_wr && addr_q == `OFF_STATUS) begin
			carry_flag <= wb[`ST_CARRY];
			half_carry_flag <= wb[`ST_HALF];
			zero_flag <= wb[`ST_ZERO];
			signed_wrap_flag <= wb[`ST_WRAP];
		end else if (alu_valid) begin
			if (c_def) begin
				carry_flag <= c_d;
			end
			if (hv_def) begin
				half_carry_flag <= h_d;
				signed_wrap_flag <= v_d;
			end
			if (z_def) begin
				zero_flag <= (res_d == 8'h00);
			end
		end
	end

	// Time-out and power-down flags: only system events reach them, never a bus write.
	// Nothing here copies status to a stack; calls leave it to software to save.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			watchdog_expired_flag <= 1'b0;
			power_down_flag <= 1'b0;
		end else begin
			if (watchdog_expired) begin
				watchdog_expired_flag <= 1'b1;
			end else if (watchdog_clear_instruction || sleep_exec) begin
				watchdog_expired_flag <= 1'b0;
			end
			if (sleep_exec) begin
				power_down_flag <= 1'b1;
			end else if (watchdog_clear_instruction) begin
				power_down_flag <= 1'b0;
			end
		end
	end

	// Bank bit: a watchdog reset taken while powered down keeps the selection.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bank_select_bit <= 1'b0;
		end else if (soft_reset) begin
			if (!(soft_reset_from_wdt && power_down_flag)) begin
				bank_select_bit <= 1'b0;
			end
		end else if (bus_wr && addr_q == `OFF_BANK) begin
			bank_select_bit <= wb[0];
		end
	end

	// Program counter low byte: a write jumps inside the page and costs one dummy cycle.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			program_counter_low_byte <= `RST_BYTE;
			pc_jump <= 1'b0;
			dummy_cycle <= 1'b0;
		end else begin
			pc_jump <= 1'b0;
			dummy_cycle <= pc_jump;
			if (bus_wr && addr_q == `OFF_PCL) begin
				program_counter_low_byte <= wb;
				pc_jump <= 1'b1;
			end
		end
	end

	// Table pointers and read: after the fetch pulse the read waits for the program word.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			table_pointer_low <= `RST_BYTE;
			table_pointer_high <= `RST_BYTE;
			table_result_high <= `RST_BYTE;
			table_low_data <= `RST_BYTE;
			table_low_valid <= 1'b0;
			table_fetch <= 1'b0;
			table_wait_q <= 1'b0;
		end else begin
			table_fetch <= 1'b0;
			table_low_valid <= 1'b0;
			if (bus_wr && addr_q == `OFF_TABLE_POINTER_LOW) begin
				table_pointer_low <= wb;
			end
			if (bus_wr && addr_q == `OFF_TABLE_POINTER_HIGH) begin
				table_pointer_high <= wb;
			end
			if (table_read_req && !table_wait_q) begin
				table_fetch <= 1'b1;
				table_wait_q <= 1'b1;
			end else if (table_wait_q && table_word_valid) begin
				table_result_high <= table_word[15:8];
				table_low_data <= table_word[7:0];
				table_low_valid <= 1'b1;
				table_wait_q <= 1'b0;
			end
		end
	end

	// Non-volatile store: no memory map of its own, only the address and data registers.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ee_addr_q <= 6'h00;
		end else if (bus_wr && addr_q == `OFF_EE_ADDR) begin
			ee_addr_q <= wb[5:0];
		end
	end

	// Store array has no reset; its content is software's to define.
	always @(posedge hclk) begin
		if (bus_wr && addr_q == `OFF_EE_DATA) begin
			ee_store[ee_addr_q] <= wb;
		end
	end

endmodule

/* testbench/core_regs_props.sv */
// Concurrent checks on the ports of the core register block.
`timescale 1ns/1ps
`include "core_regs_map.vh"
module core_regs_props (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Register bus.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Sequencer side.
	input wire logic alu_valid,
	input wire logic [3:0] alu_op,
	input wire logic [7:0] alu_operand,
	input wire logic [7:0] working_register,
	input wire logic [7:0] program_counter_low_byte,
	input wire logic pc_jump,
	input wire logic dummy_cycle,
	input wire logic table_fetch,
	input wire logic table_word_valid,
	input wire logic [15:0] table_word,
	input wire logic [7:0] table_low_data,
	input wire logic table_low_valid,
	input wire logic access_indirect_mp1,
	input wire logic access_bank
);
	logic wr_q;
	logic wait_q;
	logic [7:0] addr_q;
	wire pcl_wr = wr_q && hready && (addr_q == `OFF_PCL);
	wire wreg_wr = wr_q && hready && (addr_q == `OFF_WREG);
	wire alu_go = alu_valid && !wreg_wr;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Track the pending write and the open table fetch, since both only show up one phase later.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			addr_q <= 8'h00;
			wait_q <= 1'b0;
		end else begin
			if (hready) begin
				wr_q <= hsel && htrans[1] && hwrite;
				addr_q <= haddr[7:0];
			end
			wait_q <= table_fetch ? 1'b1 : (table_word_valid ? 1'b0 : wait_q);
		end
	end
	sequence jump_then_dummy;
		pc_jump ##1 dummy_cycle;
	endsequence
	a_pcl_jump_dummy: assert property (pcl_wr |=> jump_then_dummy) else $error("jump pulse order wrong");
	a_pcl_load_value: assert property (pcl_wr |=> program_counter_low_byte == $past(hwdata[7:0]))
		else $error("pc low byte wrong");
	a_alu_movw_load: assert property (alu_go && alu_op == `OP_MOVW |=> working_register == $past(alu_operand))
		else $error("move result wrong");
	a_alu_and_result: assert property (alu_go && alu_op == `OP_AND |=>
		working_register == ($past(working_register) & $past(alu_operand))) else $error("and result wrong");
	a_alu_add_result: assert property (alu_go && alu_op == `OP_ADD |=>
		working_register == 8'($past(working_register) + $past(alu_operand))) else $error("add result wrong");
	a_work_hold: assert property ((!alu_valid || alu_op > `OP_CPL) && !wreg_wr |=> $stable(working_register))
		else $error("working register moved");
	a_bank_direct_zero: assert property (!access_indirect_mp1 |-> !access_bank) else $error("direct hit bank 1");
	a_table_low_byte: assert property (wait_q && table_word_valid |=>
		table_low_valid && table_low_data == $past(table_word[7:0])) else $error("table low byte wrong");
	a_table_one_pulse: assert property (table_low_valid |=> !table_low_valid) else $error("low valid stuck");
	a_read_upper_zero: assert property (hrdata[31:8] == 24'h000000) else $error("upper read bits set");
endmodule
bind core_status_and_bank_regs core_regs_props props_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.alu_valid(alu_valid), .alu_op(alu_op), .alu_operand(alu_operand), .working_register(working_register),
	.program_counter_low_byte(program_counter_low_byte), .pc_jump(pc_jump), .dummy_cycle(dummy_cycle),
	.table_fetch(table_fetch), .table_word_valid(table_word_valid), .table_word(table_word),
	.table_low_data(table_low_data), .table_low_valid(table_low_valid),
	.access_indirect_mp1(access_indirect_mp1), .access_bank(access_bank));

/* testbench/tb_top.sv */
// Register bus and sequencer tests for the core register block.
`timescale 1ns/1ps
`include "core_regs_map.vh"
module tb_top;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, alu_valid = 1'b0;
	logic table_read_req = 1'b0, table_word_valid = 1'b0, access_indirect_mp1 = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [3:0] alu_op = 4'h0;
	logic [7:0] alu_operand = 8'h00;
	logic [15:0] table_word = 16'h0000;
	logic [4:0] ev = 5'h00;
	wire hready, hreadyout, hresp, pc_jump, dummy_cycle, table_fetch, table_low_valid, access_bank;
	wire [31:0] hrdata;
	wire [7:0] working_register, program_counter_low_byte, table_low_data;
	wire [15:0] table_addr;
	int miscompares = 0;
	int checked = 0;
	// The single slave drives the bus ready.
	assign hready = hreadyout;
	core_status_and_bank_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .alu_valid(alu_valid), .alu_op(alu_op), .alu_operand(alu_operand),
		.working_register(working_register), .program_counter_low_byte(program_counter_low_byte),
		.pc_jump(pc_jump), .dummy_cycle(dummy_cycle), .table_read_req(table_read_req), .table_addr(table_addr),
		.table_fetch(table_fetch), .table_word_valid(table_word_valid), .table_word(table_word),
		.table_low_data(table_low_data), .table_low_valid(table_low_valid), .sleep_exec(ev[0]),
		.watchdog_clear_instruction(ev[1]), .watchdog_expired(ev[2]), .soft_reset(ev[3]),
		.soft_reset_from_wdt(ev[4]), .access_indirect_mp1(access_indirect_mp1), .access_bank(access_bank));
	// Free running 200 MHz clock.
	always #2.5 hclk = ~hclk;
	task final_report;
		if (miscompares == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Bounded wait on ready, fetch or low valid; running out ends the run as a mismatch.
	task wait_for(input int which);
		int n;
		n = 0;
		@(posedge hclk);
		while ((which == 0 ? hready : (which == 1 ? table_fetch : table_low_valid)) !== 1'b1) begin
			n++;
			if (n > 50) begin
				miscompares++;
				final_report();
			end
			@(posedge hclk);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_for(0);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_for(0);
		r = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, a, {24'h000000, d}, r);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, {24'h000000, exp});
	endtask
	// Event pulses are one cycle wide; the gap cycle keeps a following request apart.
	task pulse(input logic [4:0] m);
		ev <= m;
		@(posedge hclk);
		ev <= 5'h00;
		@(posedge hclk);
	endtask
	task alu(input logic [3:0] op, input logic [7:0] v, input logic [7:0] exp, input logic [7:0] flags);
		alu_op <= op;
		alu_operand <= v;
		alu_valid <= 1'b1;
		@(posedge hclk);
		alu_valid <= 1'b0;
		@(posedge hclk);
		chk({24'h0, working_register}, {24'h0, exp});
		rd(`OFF_STATUS, flags);
	endtask
	// Main sequence.
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(`OFF_BANK, 8'h00);
		rd(`OFF_STATUS, 8'h00);
		wr(`OFF_BANK, 8'hff);
		rd(`OFF_BANK, 8'h01);
		access_indirect_mp1 <= 1'b1;
		@(posedge hclk);
		chk({31'h0, access_bank}, 32'h1);
		access_indirect_mp1 <= 1'b0;
		@(posedge hclk);
		chk({31'h0, access_bank}, 32'h0);
		wr(`OFF_STATUS, 8'hff);
		rd(`OFF_STATUS, 8'h0f);
		pulse(5'h04);
		rd(`OFF_STATUS, 8'h2f);
		pulse(5'h01);
		rd(`OFF_STATUS, 8'h1f);
		wr(`OFF_STATUS, 8'h00);
		rd(`OFF_STATUS, 8'h10);
		pulse(5'h18);
		rd(`OFF_BANK, 8'h01);
		pulse(5'h02);
		rd(`OFF_STATUS, 8'h00);
		pulse(5'h18);
		rd(`OFF_BANK, 8'h00);
		alu(`OP_MOVW, 8'h7f, 8'h7f, 8'h00);
		alu(`OP_ADD, 8'h01, 8'h80, 8'h0a);
		alu(`OP_SUB, 8'h80, 8'h00, 8'h07);
		alu(`OP_SUB, 8'h01, 8'hff, 8'h00);
		alu(`OP_ADD, 8'h01, 8'h00, 8'h07);
		wr(`OFF_STATUS, 8'h0b);
		alu(`OP_AND, 8'h00, 8'h00, 8'h0f);
		alu(`OP_OR, 8'h01, 8'h01, 8'h0b);
		alu(`OP_RLC, 8'h00, 8'h01, 8'h0a);
		alu(4'hf, 8'h55, 8'h01, 8'h0a);
		wr(`OFF_WREG, 8'h3c);
		rd(`OFF_WREG, 8'h3c);
		wr(`OFF_PCL, 8'ha5);
		rd(`OFF_PCL, 8'ha5);
		wr(`OFF_TABLE_POINTER_LOW, 8'h34);
		wr(`OFF_TABLE_POINTER_HIGH, 8'h12);
		// The pointer write commits at the edge the task returns on, so let it settle first.
		@(posedge hclk);
		chk({16'h0, table_addr}, 32'h1234);
		table_read_req <= 1'b1;
		wait_for(1);
		table_read_req <= 1'b0;
		table_word <= 16'hbeef;
		table_word_valid <= 1'b1;
		@(posedge hclk);
		table_word_valid <= 1'b0;
		wait_for(2);
		chk({24'h0, table_low_data}, 32'hef);
		wr(`OFF_TABLE_RESULT_HIGH, 8'h00);
		rd(`OFF_TABLE_RESULT_HIGH, 8'hbe);
		wr(`OFF_EE_ADDR, 8'hff);
		wr(`OFF_EE_DATA, 8'h5a);
		wr(`OFF_EE_ADDR, 8'h00);
		wr(`OFF_EE_DATA, 8'ha5);
		wr(`OFF_EE_ADDR, 8'h3f);
		rd(`OFF_EE_ADDR, 8'h3f);
		rd(`OFF_EE_DATA, 8'h5a);
		wr(8'h40, 8'hff);
		rd(8'h40, 8'h00);
		final_report();
	end
endmodule
